// [design/sec_pkg.sv]
// Package with register map, field positions, reset values and timing constants.
package sec_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEE = 8'h04;
  localparam logic [7:0] OFS_SMI_EN = 8'h08;
  localparam logic [7:0] OFS_IDLE_INIT = 8'h0c;
  localparam logic [7:0] OFS_HALT_LOW = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1c;

  // Control register field positions.
  localparam int CTRL_HALT_EN = 0;
  localparam int CTRL_HALT_START = 1;
  localparam int CTRL_IDLE_SMI_EN = 2;
  localparam int CTRL_SMI_VIA_PIC = 3;
  localparam int CTRL_GRANT_WAIT_SEL = 6;
  localparam int CTRL_GATE = 8;

  // Status register field positions.
  localparam int STAT_HALT = 8;
  localparam int STAT_GRANT = 9;
  localparam int STAT_MGMT = 10;

  // Interrupt status bits.
  localparam int INT_SYS_EVENT = 0;
  localparam int INT_IDLE_EXP = 1;
  localparam int INT_HALT_REL = 2;

  // The 14 interrupt request inputs that exist; bits 0 and 2 have no pin.
  localparam logic [15:0] IRQ_PRESENT = 16'hfffa;

  // Reset values.
  localparam logic [7:0] IDLE_INIT_RST = 8'hff;
  localparam logic [7:0] HALT_LOW_RST = 8'h01;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: clock, halt timer tick and idle timer tick.
  localparam longint CLK_HZ = 100000000;
  localparam int SCALE_TICK_NS = 32000;
  localparam int SCALE_TICK_CYC = (SCALE_TICK_NS + 9) / 10;
  localparam longint IDLE_TICK_S = 60;
  localparam longint IDLE_TICK_CYC = IDLE_TICK_S * CLK_HZ;

  // Halt controller states, one-hot.
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_WAIT = 3'b010,
    ST_LOW = 3'b100
  } sec_state_t;

  // Software configuration carried as one group.
  typedef struct packed {
    logic halt_en;
    logic idle_smi_en;
    logic smi_via_pic;
    logic grant_wait_sel;
    logic [15:0] sys_event_enable;
    logic [15:0] smi_en;
    logic [7:0] idle_init;
    logic [7:0] halt_low;
    logic [2:0] int_mask;
  } sec_cfg_t;

endpackage

// [design/sec_stop_clock_ctl.sv]
// System event detection, idle timer, management interrupt gate and halt-clock control.
// What this block does
// - With grant wait select at 0 the block acts on the first halt grant, then releases the halt on timer expiry or a break event.
// - An interrupt enabled to raise a management interrupt stays blocked while the gate bit is set, whatever its routing.
// - Each of the 14 interrupt inputs can raise a system event, enabled by its own bit of the 16-bit enable field.
// - An enabled interrupt event reloads the idle timer and, once the halt timer is running, releases the halt-clock output.
// - Enabled interrupt inputs are sampled as level-sensitive, active-high signals.
// - Management interrupts leave through the dedicated output or the interrupt controller path, chosen by software.
// - The idle timer counts down one per minute from its start value, may raise a management interrupt at zero, and reloads on every system event.
// - The management interrupt stays asserted until the handler clears the gate bit, whatever the halt state.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module sec_stop_clock_ctl
  import sec_pkg::*;
#(
  parameter longint MINUTE_CYCLES = sec_pkg::IDLE_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [15:0] irq_pins,
  input wire logic halt_grant_cycle,
  input wire logic break_event,
  output logic cpu_halt_clk_n,
  output logic mgmt_irq_n,
  output logic mgmt_irq_pic,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sec_pkg::*;

  // Two-flop synchronisers on the asynchronous interrupt pins; only stage two is read.
  logic [15:0] irq_meta_ff;
  logic [15:0] irq_sync_ff;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_sync
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          irq_meta_ff[gi] <= 1'b0;
          irq_sync_ff[gi] <= 1'b0;
        end else begin
          irq_meta_ff[gi] <= irq_pins[gi];
          irq_sync_ff[gi] <= irq_meta_ff[gi];
        end
      end
    end
  endgenerate

  // State registers.
  sec_cfg_t cfg_ff, nxt_cfg;
  sec_state_t st_ff, nxt_st;
  logic [7:0] idle_cnt_ff, nxt_idle_cnt;
  logic [7:0] halt_cnt_ff, nxt_halt_cnt;
  logic [33:0] min_div_ff, nxt_min_div;
  logic [11:0] scl_div_ff, nxt_scl_div;
  logic gate_ff, nxt_gate;
  logic grant_seen_ff, nxt_grant_seen;
  logic [2:0] int_stat_ff, nxt_int_stat;
  logic aw_have_ff, nxt_aw_have;
  logic w_have_ff, nxt_w_have;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  // Decoded helpers.
  logic [15:0] irq_live;
  logic [15:0] irq_blocked;
  logic sys_event;
  logic minute_tick;
  logic scale_tick;
  logic do_wr;
  logic [31:0] wmask;
  logic [31:0] wv;
  logic gate_clr_wr;
  logic init_wr;
  logic idle_expire;
  logic smi_irq_event;
  logic halt_release;

  // Bus handshakes are combinational; one write and one read in flight at most.
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign cpu_halt_clk_n = !(st_ff != ST_RUN);
  // The gate flop itself is the interrupt, so it holds until software clears it.
  assign mgmt_irq_n = !(gate_ff && !cfg_ff.smi_via_pic);
  assign mgmt_irq_pic = gate_ff && cfg_ff.smi_via_pic;
  assign irq = |(int_stat_ff & cfg_ff.int_mask);

  // Level-sensitive event detection with the gate blocking SMI-enabled inputs.
  always_comb begin
    irq_blocked = cfg_ff.smi_en & {16{gate_ff}};
    irq_live = irq_sync_ff & cfg_ff.sys_event_enable & IRQ_PRESENT & ~irq_blocked;
    sys_event = |irq_live;
    smi_irq_event = |(irq_live & cfg_ff.smi_en);
    minute_tick = (min_div_ff == 34'(MINUTE_CYCLES - 1));
    scale_tick = (scl_div_ff == 12'(SCALE_TICK_CYC - 1));
    do_wr = aw_have_ff && w_have_ff && !bvalid_ff;
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{wstrb_ff[b]}};
    end
    wv = wdata_ff & wmask;
    gate_clr_wr = do_wr && aw_addr_ff == OFS_CTRL && wmask[CTRL_GATE] && !wv[CTRL_GATE];
    init_wr = do_wr && aw_addr_ff == OFS_IDLE_INIT && wstrb_ff[0];
  end

  // Next-state logic for registers, timers, halt controller and bus.
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_st = st_ff;
    nxt_idle_cnt = idle_cnt_ff;
    nxt_halt_cnt = halt_cnt_ff;
    nxt_min_div = minute_tick ? 34'h0 : min_div_ff + 34'h1;
    nxt_scl_div = scale_tick ? 12'h0 : scl_div_ff + 12'h1;
    nxt_gate = gate_ff;
    nxt_grant_seen = grant_seen_ff;
    nxt_int_stat = int_stat_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    idle_expire = 1'b0;
    halt_release = 1'b0;

    // Capture address and data in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_have = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_have = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    // Register writes; strobes mask each byte lane.
    if (do_wr) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      case (aw_addr_ff)
        OFS_CTRL: begin
          if (wstrb_ff[0]) begin
            nxt_cfg.halt_en = wv[CTRL_HALT_EN];
            nxt_cfg.idle_smi_en = wv[CTRL_IDLE_SMI_EN];
            nxt_cfg.smi_via_pic = wv[CTRL_SMI_VIA_PIC];
            nxt_cfg.grant_wait_sel = wv[CTRL_GRANT_WAIT_SEL];
          end
        end
        OFS_SEE: nxt_cfg.sys_event_enable = (cfg_ff.sys_event_enable & ~wmask[15:0]) | wv[15:0];
        OFS_SMI_EN: nxt_cfg.smi_en = (cfg_ff.smi_en & ~wmask[15:0]) | wv[15:0];
        OFS_IDLE_INIT: nxt_cfg.idle_init = wstrb_ff[0] ? wv[7:0] : cfg_ff.idle_init;
        OFS_HALT_LOW: nxt_cfg.halt_low = wstrb_ff[0] ? wv[7:0] : cfg_ff.halt_low;
        OFS_STATUS: nxt_bresp = RESP_OKAY;
        OFS_INT_STAT: nxt_int_stat = int_stat_ff & ~wv[2:0];
        OFS_INT_MASK: nxt_cfg.int_mask = wstrb_ff[0] ? wv[2:0] : cfg_ff.int_mask;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end

    // Idle timer: one count per minute, reloaded by every system event.
    if (sys_event || init_wr) begin
      nxt_idle_cnt = init_wr ? wv[7:0] : cfg_ff.idle_init;
    end else if (minute_tick && idle_cnt_ff != 8'h00) begin
      nxt_idle_cnt = idle_cnt_ff - 8'h01;
      idle_expire = (idle_cnt_ff == 8'h01);
    end

    // Gate set by a management event, cleared only by the handler; a set wins the clear.
    if (gate_clr_wr) begin
      nxt_gate = 1'b0;
    end
    if ((idle_expire && cfg_ff.idle_smi_en) || smi_irq_event) begin
      nxt_gate = 1'b1;
    end

    // Halt controller. Breaks before the grant are held off in the wait state (grant wait select at 0) so the processor is not left halted.
    case (st_ff)
      ST_RUN: begin
        nxt_grant_seen = 1'b0;
        if (do_wr && aw_addr_ff == OFS_CTRL && wv[CTRL_HALT_START] && nxt_cfg.halt_en) begin
          nxt_halt_cnt = cfg_ff.halt_low;
          nxt_st = nxt_cfg.grant_wait_sel ? ST_LOW : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!cfg_ff.halt_en) begin
          nxt_st = ST_RUN;
          halt_release = 1'b1;
        end else if (halt_grant_cycle) begin
          nxt_grant_seen = 1'b1;
          nxt_st = ST_LOW;
        end
      end
      ST_LOW: begin
        if (halt_grant_cycle) begin
          nxt_grant_seen = 1'b1;
        end
        if (!cfg_ff.halt_en || break_event || sys_event) begin
          nxt_st = ST_RUN;
          halt_release = 1'b1;
        end else if (scale_tick) begin
          if (halt_cnt_ff <= 8'h01) begin
            nxt_st = ST_RUN;
            halt_release = 1'b1;
          end else begin
            nxt_halt_cnt = halt_cnt_ff - 8'h01;
          end
        end
      end
      default: nxt_st = ST_RUN;
    endcase

    // Sticky interrupt status; a new event beats a simultaneous clear.
    nxt_int_stat = nxt_int_stat | {halt_release, idle_expire, sys_event};

    // Register reads, answered one cycle after the address is taken.
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = 32'h0;
      case (s_axi_araddr)
        OFS_CTRL: begin
          nxt_rdata[CTRL_HALT_EN] = cfg_ff.halt_en;
          nxt_rdata[CTRL_IDLE_SMI_EN] = cfg_ff.idle_smi_en;
          nxt_rdata[CTRL_SMI_VIA_PIC] = cfg_ff.smi_via_pic;
          nxt_rdata[CTRL_GRANT_WAIT_SEL] = cfg_ff.grant_wait_sel;
          nxt_rdata[CTRL_GATE] = gate_ff;
        end
        OFS_SEE: nxt_rdata[15:0] = cfg_ff.sys_event_enable;
        OFS_SMI_EN: nxt_rdata[15:0] = cfg_ff.smi_en;
        OFS_IDLE_INIT: nxt_rdata[7:0] = cfg_ff.idle_init;
        OFS_HALT_LOW: nxt_rdata[7:0] = cfg_ff.halt_low;
        OFS_STATUS: begin
          nxt_rdata[7:0] = idle_cnt_ff;
          nxt_rdata[STAT_HALT] = (st_ff != ST_RUN);
          nxt_rdata[STAT_GRANT] = grant_seen_ff;
          nxt_rdata[STAT_MGMT] = gate_ff;
        end
        OFS_INT_STAT: nxt_rdata[2:0] = int_stat_ff;
        OFS_INT_MASK: nxt_rdata[2:0] = cfg_ff.int_mask;
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
  end

  // Register stage only.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_ff <= '{halt_en: 1'b0, idle_smi_en: 1'b0, smi_via_pic: 1'b0, grant_wait_sel: 1'b0,
                  sys_event_enable: 16'h0000, smi_en: 16'h0000, idle_init: IDLE_INIT_RST,
                  halt_low: HALT_LOW_RST, int_mask: 3'h0};
      st_ff <= ST_RUN;
      idle_cnt_ff <= IDLE_INIT_RST;
      halt_cnt_ff <= 8'h00;
      min_div_ff <= 34'h0;
      scl_div_ff <= 12'h0;
      gate_ff <= 1'b0;
      grant_seen_ff <= 1'b0;
      int_stat_ff <= 3'h0;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0;
    end else begin
      cfg_ff <= nxt_cfg;
      st_ff <= nxt_st;
      idle_cnt_ff <= nxt_idle_cnt;
      halt_cnt_ff <= nxt_halt_cnt;
      min_div_ff <= nxt_min_div;
      scl_div_ff <= nxt_scl_div;
      gate_ff <= nxt_gate;
      grant_seen_ff <= nxt_grant_seen;
      int_stat_ff <= nxt_int_stat;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      aw_addr_ff <= nxt_aw_addr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // Checks on halt, gate, event and timer behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_waiting_no_grant;
    st_ff == ST_WAIT && !halt_grant_cycle && cfg_ff.halt_en;
  endsequence
  sequence s_first_grant;
    st_ff == ST_WAIT && halt_grant_cycle && cfg_ff.halt_en;
  endsequence

  a_halt_holds_wait: assert property (s_waiting_no_grant |=> !cpu_halt_clk_n)
    else $error("halt released before the first grant");
  a_grant_starts_timer: assert property (s_first_grant |=> st_ff == ST_LOW ##0 grant_seen_ff)
    else $error("first grant did not start the halt timer");
  a_break_releases: assert property (st_ff == ST_LOW && (break_event || sys_event)
    |=> cpu_halt_clk_n && int_stat_ff[INT_HALT_REL])
    else $error("break did not release the halt");
  a_event_release: assert property (st_ff == ST_LOW && sys_event |=> cpu_halt_clk_n)
    else $error("system event did not release the halt");
  a_gate_blocks_irq: assert property (gate_ff && (irq_sync_ff & cfg_ff.sys_event_enable & IRQ_PRESENT
    & ~cfg_ff.smi_en) == 16'h0 |-> !sys_event)
    else $error("blocked interrupt raised a system event");
  // A write of the start value in the same cycle loads the written value instead.
  a_level_event: assert property (!init_wr &&
    (irq_sync_ff & cfg_ff.sys_event_enable & IRQ_PRESENT & ~cfg_ff.smi_en) != 16'h0
    |-> sys_event ##1 idle_cnt_ff == $past(cfg_ff.idle_init))
    else $error("enabled level did not reload the idle timer");
  a_idle_countdown: assert property (minute_tick && idle_cnt_ff > 8'h01 && !sys_event
    && !init_wr |=> idle_cnt_ff == $past(idle_cnt_ff) - 8'h01)
    else $error("idle timer did not count down by one");
  a_gate_holds_smi: assert property (gate_ff && !gate_clr_wr |=> gate_ff)
    else $error("management interrupt dropped without a gate clear");
  a_smi_route: assert property (gate_ff |-> (mgmt_irq_n == cfg_ff.smi_via_pic)
    && (mgmt_irq_pic == cfg_ff.smi_via_pic))
    else $error("management interrupt on the wrong path");

endmodule

// [dv/sec_cpu_model.sv]
// Model of the two processors that answer a halt-clock request with grant cycles.
`timescale 1ns/1ps
module sec_cpu_model #(
  parameter int DLY_A = 3,
  parameter int DLY_B = 7
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cpu_halt_clk_n,
  input wire logic respond,
  output logic halt_grant_cycle
);
  int cnt_ff;
  // Cycles since the request went low; a stalled model holds its count.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 0;
    end else if (cpu_halt_clk_n) begin
      cnt_ff <= 0;
    end else if (respond) begin
      cnt_ff <= cnt_ff + 1;
    end
  end
  // Both processors answer once each, on separate cycles, as the bridge forwards them.
  assign halt_grant_cycle = !cpu_halt_clk_n && respond &&
    (cnt_ff == DLY_A || cnt_ff == DLY_B);
endmodule

// [dv/system_event_stop_clock_ctl_test.sv]
// Self-checking testbench for the system event and halt-clock controller.
`timescale 1ns/1ps
module system_event_stop_clock_ctl_test;
  import sec_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} sec_row_t;
  logic sys_clk, reset, break_event, respond, halt_grant_cycle, cpu_halt_clk_n;
  logic mgmt_irq_n, mgmt_irq_pic, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] irq_pins;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int miscompares, checks;
  // Ordinary register cases: offset, written word, expected read word, expected response.
  sec_row_t rows [6] = '{
    '{OFS_SEE, 32'h1234, 32'h1234, RESP_OKAY},
    '{OFS_SMI_EN, 32'h0005, 32'h0005, RESP_OKAY},
    '{OFS_IDLE_INIT, 32'h05, 32'h05, RESP_OKAY},
    '{OFS_HALT_LOW, 32'h02, 32'h02, RESP_OKAY},
    '{OFS_INT_MASK, 32'h05, 32'h05, RESP_OKAY},
    '{8'h20, 32'h5a, 32'h00, RESP_SLVERR}};

  sec_stop_clock_ctl #(.MINUTE_CYCLES(20)) i_sec_stop_clock_ctl (.sys_clk, .reset, .irq_pins,
    .halt_grant_cycle, .break_event, .cpu_halt_clk_n, .mgmt_irq_n, .mgmt_irq_pic, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sec_cpu_model i_sec_cpu_model (.sys_clk, .reset, .cpu_halt_clk_n, .respond, .halt_grant_cycle);

  // A 10 ns clock.
  always #5 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Waits a bounded time for a level, then compares it.
  task automatic wait_lvl(ref logic sig, input logic val, input int lim);
    int n;
    n = 0;
    while (sig !== val && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    chk(sig, val);
  endtask

  // Write address and data are offered together and each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (!aw_done && s_axi_awready === 1) begin
        aw_done = 1;
        s_axi_awvalid <= 0;
      end
      if (!w_done && s_axi_wready === 1) begin
        w_done = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1);
    resp = s_axi_bresp;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge sys_clk); while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The longest test is the timed release, so a limit far beyond the sum cuts a hang.
  initial begin
    tick(50000);
    miscompares++;
    report_and_stop();
  end

  initial begin
    {sys_clk, break_event, respond, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    // Response readies stay high, so back-to-back transfers never toggle them in one step.
    {s_axi_bready, s_axi_rready} = 2'b11;
    irq_pins = 16'h0000;
    reset = 1;
    tick(1);
    chk({cpu_halt_clk_n, mgmt_irq_n, mgmt_irq_pic, irq}, 32'hc);
    tick(1);
    reset <= 0;
    tick(1);
    rd_reg(OFS_IDLE_INIT);
    chk(rd, {24'h0, IDLE_INIT_RST});
    rd_reg(OFS_HALT_LOW);
    chk(rd, {24'h0, HALT_LOW_RST});
    $display("test reset done");
    // Table of ordinary register accesses.
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(resp, rows[i].r);
      rd_reg(rows[i].a);
      chk(resp, rows[i].r);
      chk(rd, rows[i].e);
    end
    $display("test register table done");
    // Each input raises an event only when enabled, and only if the pin exists.
    for (int i = 0; i < 16; i++) begin
      wr(OFS_SEE, ~(32'h1 << i));
      wr(OFS_INT_STAT, 32'h7);
      irq_pins[i] <= 1;
      tick(6);
      rd_reg(OFS_INT_STAT);
      chk(rd & 32'h1, 32'h0);
      wr(OFS_SEE, 32'h1 << i);
      tick(2);
      rd_reg(OFS_INT_STAT);
      chk(rd & 32'h1, {31'h0, IRQ_PRESENT[i]});
      chk(irq, IRQ_PRESENT[i]);
      irq_pins[i] <= 0;
      tick(6);
    end
    $display("test event inputs done");
    // Halt released by a break, by a system event and by the halt timer.
    wr(OFS_SEE, 32'h8);
    wr(OFS_INT_STAT, 32'h7);
    for (int k = 0; k < 3; k++) begin
      respond <= 0;
      wr(OFS_CTRL, 32'h3);
      tick(1);
      chk(cpu_halt_clk_n, 0);
      break_event <= 1;
      tick(3);
      chk(cpu_halt_clk_n, 0);
      break_event <= 0;
      respond <= 1;
      tick(12);
      rd_reg(OFS_STATUS);
      chk(rd[STAT_GRANT], 1);
      if (k == 0) break_event <= 1;
      if (k == 1) irq_pins[3] <= 1;
      wait_lvl(cpu_halt_clk_n, 1, (k == 2) ? 3 * SCALE_TICK_CYC + 40 : 6);
      break_event <= 0;
      irq_pins[3] <= 0;
      rd_reg(OFS_INT_STAT);
      chk(rd & 32'h5, (k == 1) ? 32'h5 : 32'h4);
      wr(OFS_INT_STAT, 32'h7);
      tick(4);
      chk(irq, 0);
    end
    $display("test halt release done");
    // Idle timer is held by a system event, then expires into a management interrupt.
    irq_pins[3] <= 1;
    tick(4);
    wr(OFS_IDLE_INIT, 32'h3);
    wr(OFS_CTRL, 32'h4);
    tick(100);
    chk(mgmt_irq_n, 1);
    irq_pins[3] <= 0;
    tick(30);
    chk(mgmt_irq_n, 1);
    wait_lvl(mgmt_irq_n, 0, 80);
    tick(50);
    chk(mgmt_irq_n, 0);
    rd_reg(OFS_STATUS);
    chk(rd[STAT_MGMT], 1);
    wr(OFS_CTRL, 32'h0);
    tick(2);
    chk(mgmt_irq_n, 1);
    $display("test idle timer done");
    // Interrupt path routing and blocking until the gate is cleared.
    // The input must be event-enabled as well as management-enabled to reach the gate.
    wr(OFS_SMI_EN, 32'h10);
    wr(OFS_SEE, 32'h10);
    wr(OFS_CTRL, 32'h8);
    irq_pins[4] <= 1;
    wait_lvl(mgmt_irq_pic, 1, 10);
    chk(mgmt_irq_n, 1);
    // With the gate set the still-high input must raise no further system event.
    wr(OFS_INT_STAT, 32'h7);
    rd_reg(OFS_INT_STAT);
    chk(rd & 32'h1, 32'h0);
    irq_pins[4] <= 0;
    tick(20);
    chk(mgmt_irq_pic, 1);
    wr(OFS_CTRL, 32'h0);
    tick(2);
    chk({mgmt_irq_pic, mgmt_irq_n}, 32'h1);
    irq_pins[4] <= 1;
    wait_lvl(mgmt_irq_n, 0, 10);
    irq_pins[4] <= 0;
    tick(6);
    wr(OFS_CTRL, 32'h0);
    tick(2);
    chk(mgmt_irq_n, 1);
    $display("test interrupt paths done");
    // A reset in mid-run with the halt requested must return outputs and registers to idle.
    respond <= 0;
    wr(OFS_CTRL, 32'h3);
    tick(1);
    chk(cpu_halt_clk_n, 0);
    reset <= 1;
    tick(2);
    chk({cpu_halt_clk_n, mgmt_irq_n, mgmt_irq_pic, irq}, 32'hc);
    reset <= 0;
    tick(2);
    chk({cpu_halt_clk_n, mgmt_irq_n, mgmt_irq_pic, irq}, 32'hc);
    rd_reg(OFS_IDLE_INIT);
    chk(rd, {24'h0, IDLE_INIT_RST});
    rd_reg(OFS_SEE);
    chk(rd, 32'h0);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
